// [design/acs_pkg.sv]
package acs_pkg;

  // register indices; byte address is four times the index
  localparam logic [15:0] ACS_IDX_RESULT  = 16'h402d;
  localparam logic [15:0] ACS_IDX_CONTROL = 16'h402e;
  localparam logic [15:0] ACS_IDX_SOURCE  = 16'h402f;
  localparam logic [15:0] ACS_IDX_IRQ_STS = 16'h4040;
  localparam logic [15:0] ACS_IDX_IRQ_EN  = 16'h4041;

  ////////////////////////////////////////////////////////////////////////////
  // control field positions
  localparam int ACS_CTL_ENA   = 15;
  localparam int ACS_CTL_CVT   = 14;
  localparam int ACS_CTL_SLP   = 12;
  localparam int ACS_RATE_W    = 6;

  // source select layout; tag is bit position plus one
  localparam int              ACS_SRC_W    = 7;
  localparam logic [6:0]      ACS_SRC_MASK = 7'h57;
  localparam logic [2:0]      ACS_SRC_LAST = 3'h6;
  localparam int              ACS_DATA_W   = 12;
  localparam int              ACS_TAG_LSB  = 12;

  // rate codes
  localparam logic [5:0] ACS_RATE_MANUAL = 6'h00;
  localparam logic [5:0] ACS_RATE_RSVD   = 6'h20;
  localparam int         ACS_RATE_LO_MUL = 2;
  localparam int         ACS_RATE_HI_MUL = 16;

  // interrupt status bits
  localparam int         ACS_IRQ_DONE = 0;
  localparam int         ACS_IRQ_LOST = 1;
  localparam int         ACS_IRQ_W    = 2;

  // reset values
  localparam logic [15:0] ACS_RST_RESULT = 16'h0000;
  localparam logic [5:0]  ACS_RST_RATE   = 6'h00;
  localparam logic [6:0]  ACS_RST_SOURCE = 7'h00;
  localparam logic [1:0]  ACS_RST_IRQ_EN = 2'h0;

  // system clock rate in hertz
  localparam int ACS_CLK_HZ = 40_000_000;

  typedef enum logic [1:0]
  {
    ACS_IDLE  = 2'b00,
    ACS_START = 2'b01,
    ACS_WAIT  = 2'b11
  } acs_state_t;

endpackage

// [design/acs_rate_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module acs_rate_timer
  import acs_pkg::*;
#(
  parameter int CLK_HZ = ACS_CLK_HZ
)
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // control
  input  wire logic [5:0] rate_code_i,
  input  wire logic       run_i,
  // trigger
  output logic            tick_o
);

  localparam int ACC_W = $clog2(CLK_HZ) + 2;

  logic [ACC_W-1:0] acc_r;
  logic [ACC_W-1:0] step;
  logic [ACC_W-1:0] sum;

  ////////////////////////////////////////////////////////////////////////////
  // fractional accumulator gives the exact mean rate without a divider
  always_comb
  begin
    if (rate_code_i < ACS_RATE_RSVD)                                    // [RULE5]
      step = ACC_W'(int'(rate_code_i) * ACS_RATE_LO_MUL);
    else if (rate_code_i == ACS_RATE_RSVD)                              // [RULE5]
      step = '0;
    else
      step = ACC_W'((int'(rate_code_i) - int'(ACS_RATE_RSVD)) * ACS_RATE_HI_MUL);
    sum = acc_r + step;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      acc_r  <= '0;
      tick_o <= 1'b0;
    end
    else if (!run_i || step == '0)
    begin
      acc_r  <= '0;
      tick_o <= 1'b0;
    end
    else if (sum >= ACC_W'(CLK_HZ))
    begin
      acc_r  <= sum - ACC_W'(CLK_HZ);
      tick_o <= 1'b1;
    end
    else
    begin
      acc_r  <= sum;
      tick_o <= 1'b0;
    end
  end

  rsvd_silent_a : assert property (@(posedge clk_i) disable iff (rst_i)
    rate_code_i == ACS_RATE_RSVD |=> !tick_o) else $error("tick on reserved code"); // [RULE5]

endmodule // acs_rate_timer
`default_nettype wire

// [design/acs_sequencer.sv]
// Operation
// RULE1: converter runs only when enabled; OFF clears enable
// RULE2: SLEEP disables converter unless sleep enable set
// RULE3: nonzero rate: conversion bit starts repeated conversions
// RULE4: manual: one conversion per write, bit self-clears
// RULE5: rate code sets automatic trigger rate
// RULE6: software waits for interrupt before reading result
// RULE7: five sources, each gated by own select bit
// RULE8: select bits 6,4,2,1,0 map to sources
// RULE9: each trigger advances to next enabled source
// RULE10: one trigger yields exactly one measurement
// RULE11: sequence order is ascending source bit position
// RULE12: completed measurement overwrites result with source tag
// RULE13: manual mode: interrupt confirms completed measurement
// RULE14: no source selected: no measurement, bit cleared; the code clears the bit in manual mode only, automatic mode keeps it set
//
// The Avalon-MM register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer
  import acs_pkg::*;
#(
  parameter int CLK_HZ = ACS_CLK_HZ
)
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // avalon-mm slave, word addressed
  input  wire logic [15:0] avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // power state
  input  wire logic        off_state_i,
  input  wire logic        sleep_state_i,
  // analogue converter
  output logic             conv_enable_o,
  output logic             conv_start_o,
  output logic      [3:0]  conv_source_o,
  input  wire logic        conv_done_i,
  input  wire logic [11:0] conv_data_i,
  // interrupt
  output logic             irq_o
);

  acs_state_t       state_r;
  logic             ena_r;
  logic             cvt_r;
  logic             slp_r;
  logic [5:0]       rate_r;
  logic [6:0]       src_sel_r;
  logic [2:0]       last_r;
  logic [15:0]      result_r;
  logic [1:0]       irq_sts_r;
  logic [1:0]       irq_en_r;
  logic [1:0]       rd_sts_r;
  logic             ack_r;
  logic             req;
  logic             wr_done;
  logic             rd_done;
  logic [15:0]      lane_m;
  logic [15:0]      ctl_cur;
  logic [15:0]      ctl_nxt;
  logic             active;
  logic             manual;
  logic             idle;
  logic             tick;
  logic             trig;
  logic             have_src;
  logic             man_done;
  logic             cvt_clear;
  logic [2:0]       src_nxt;
  logic [1:0]       irq_set;

  ////////////////////////////////////////////////////////////////////////////
  // bus slave: one wait cycle, answer on the second edge

  assign req               = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~ack_r;
  assign wr_done           = avs_write_i & ack_r;
  assign rd_done           = avs_read_i & ack_r;
  assign lane_m            = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

  assign ctl_cur = {ena_r, cvt_r, 1'b0, slp_r, 6'h00, rate_r};
  assign ctl_nxt = (ctl_cur & ~lane_m) | (avs_writedata_i[15:0] & lane_m);

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      ack_r <= 1'b0;
    else
      ack_r <= req & ~ack_r;
  end

  // read data captured on the first cycle, stands at the answering edge
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      avs_readdata_o <= 32'h0000_0000;
      rd_sts_r       <= 2'h0;
    end
    else if (avs_read_i && !ack_r)
    begin
      rd_sts_r <= 2'h0;
      case (avs_address_i)
        ACS_IDX_RESULT:  avs_readdata_o <= {16'h0000, result_r};
        ACS_IDX_CONTROL: avs_readdata_o <= {16'h0000, ctl_cur};
        ACS_IDX_SOURCE:  avs_readdata_o <= {25'h0, src_sel_r};
        ACS_IDX_IRQ_STS:
        begin
          avs_readdata_o <= {30'h0, irq_sts_r};
          rd_sts_r       <= irq_sts_r;
        end
        ACS_IDX_IRQ_EN:  avs_readdata_o <= {30'h0, irq_en_r};
        default:         avs_readdata_o <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      ena_r <= 1'b0;
    else if (off_state_i)
      ena_r <= 1'b0;                                                    // [RULE1]
    else if (wr_done && avs_address_i == ACS_IDX_CONTROL)
      ena_r <= ctl_nxt[ACS_CTL_ENA];
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      slp_r  <= 1'b0;
      rate_r <= ACS_RST_RATE;
    end
    else if (wr_done && avs_address_i == ACS_IDX_CONTROL)
    begin
      slp_r  <= ctl_nxt[ACS_CTL_SLP];
      rate_r <= ctl_nxt[ACS_RATE_W-1:0];
    end
  end

  // a software write wins over the hardware clear of the same cycle
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      cvt_r <= 1'b0;
    else if (wr_done && avs_address_i == ACS_IDX_CONTROL)
      cvt_r <= ctl_nxt[ACS_CTL_CVT];
    else if (cvt_clear)
      cvt_r <= 1'b0;                                                    // [RULE4] [RULE14]
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      src_sel_r <= ACS_RST_SOURCE;
    else if (wr_done && avs_address_i == ACS_IDX_SOURCE && avs_byteenable_i[0])
      src_sel_r <= avs_writedata_i[6:0] & ACS_SRC_MASK;                 // [RULE7] [RULE8]
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      irq_en_r <= ACS_RST_IRQ_EN;
    else if (wr_done && avs_address_i == ACS_IDX_IRQ_EN && avs_byteenable_i[0])
      irq_en_r <= avs_writedata_i[1:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // trigger generation

  assign active = ena_r & ~off_state_i & (~sleep_state_i | slp_r);     // [RULE1] [RULE2]
  assign manual = (rate_r == ACS_RATE_MANUAL);
  assign idle   = (state_r == ACS_IDLE);

  assign conv_enable_o = active;

  acs_rate_timer #(
    .CLK_HZ (CLK_HZ)
  ) u_rate (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .rate_code_i (rate_r),
    .run_i       (active & cvt_r & ~manual),                            // [RULE3]
    .tick_o      (tick)
  );

  // manual: bit held until done; auto: one tick per measurement
  assign trig      = idle & active & cvt_r & (manual | tick);           // [RULE3] [RULE4] [RULE10]
  assign have_src  = |src_sel_r;
  assign man_done  = manual & (state_r == ACS_WAIT) & conv_done_i;
  assign cvt_clear = man_done | (manual & trig & ~have_src);            // [RULE4] [RULE14]

  // next enabled source after the last one, lowest offset wins
  function automatic logic [2:0] next_src(input logic [6:0] sel, input logic [2:0] last);
    logic [2:0] idx;
    logic [2:0] res;
    res = last;
    for (int i = ACS_SRC_W; i >= 1; i--)
    begin
      idx = 3'((int'(last) + i) % ACS_SRC_W);
      if (sel[idx])
        res = idx;
    end
    return res;
  endfunction

  assign src_nxt = next_src(src_sel_r, last_r);                         // [RULE9] [RULE11]

  ////////////////////////////////////////////////////////////////////////////
  // measurement sequence

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_r <= ACS_IDLE;
      last_r  <= ACS_SRC_LAST;
    end
    else
    begin
      case (state_r)
        ACS_IDLE:
        begin
          if (trig && have_src)                                         // [RULE14]
          begin
            state_r <= ACS_START;
            last_r  <= src_nxt;                                         // [RULE9]
          end
        end
        ACS_START:
          state_r <= ACS_WAIT;
        ACS_WAIT:
        begin
          if (conv_done_i)
            state_r <= ACS_IDLE;
        end
        default:
          state_r <= ACS_IDLE;
      endcase
    end
  end

  assign conv_start_o  = (state_r == ACS_START);                        // [RULE10]
  assign conv_source_o = {1'b0, last_r} + 4'h1;                         // [RULE8]

  // limitation: previous result is lost if not read before the next one
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      result_r <= ACS_RST_RESULT;
    else if (state_r == ACS_WAIT && conv_done_i)
      result_r <= {conv_source_o, conv_data_i};                         // [RULE12]
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts: sticky, cleared by reading, a new event wins

  assign irq_set[ACS_IRQ_DONE] = (state_r == ACS_WAIT) & conv_done_i;   // [RULE13]
  assign irq_set[ACS_IRQ_LOST] = tick & ~idle & cvt_r & active;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      irq_sts_r <= 2'h0;
    else if (rd_done && avs_address_i == ACS_IDX_IRQ_STS)
      irq_sts_r <= (irq_sts_r & ~rd_sts_r) | irq_set;
    else
      irq_sts_r <= irq_sts_r | irq_set;
  end

  assign irq_o = |(irq_sts_r & irq_en_r);

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_launch;
    state_r == ACS_START ##1 state_r == ACS_WAIT;
  endsequence

  off_clears_ena_a : assert property ( // [RULE1]
    off_state_i |=> !ena_r && !conv_enable_o)
    else $error("enable survived off state");

  sleep_gate_a : assert property ( // [RULE2]
    sleep_state_i && !slp_r |-> !conv_enable_o && !trig)
    else $error("converter active in sleep");

  auto_start_a : assert property ( // [RULE3]
    tick && idle && active && cvt_r && !manual && have_src |=> s_launch)
    else $error("automatic trigger did not launch");

  manual_once_a : assert property ( // [RULE4]
    man_done && !wr_done |=> !cvt_r && idle ##1 idle)
    else $error("manual bit not cleared after done");

  source_gated_a : assert property ( // [RULE7]
    conv_start_o |-> src_sel_r[last_r])
    else $error("disabled source measured");

  single_meas_a : assert property ( // [RULE10]
    conv_start_o |=> !conv_start_o [*2])
    else $error("more than one start per trigger");

  // last_r moves on the trigger edge, so at the start pulse its past is the previous source
  ascend_order_a : assert property ( // [RULE11]
    conv_start_o |->
      (last_r > $past(last_r) &&
       (src_sel_r & ~(7'h7f << last_r) & (7'h7f << ($past(last_r) + 3'h1))) == 7'h00) ||
      (last_r <= $past(last_r) &&
       (src_sel_r & (7'h7f << ($past(last_r) + 3'h1))) == 7'h00 &&
       (src_sel_r & ~(7'h7f << last_r)) == 7'h00))
    else $error("source order not ascending");

  result_write_a : assert property ( // [RULE12]
    state_r == ACS_WAIT && conv_done_i
    |=> result_r == {$past(conv_source_o), $past(conv_data_i)})
    else $error("result not written with tag");

  done_irq_a : assert property ( // [RULE13]
    man_done |=> irq_sts_r[ACS_IRQ_DONE])
    else $error("done status not raised");

  empty_trig_a : assert property ( // [RULE14]
    trig && !have_src && manual && !wr_done |=> !cvt_r && $stable(result_r) && idle)
    else $error("empty trigger measured");

  enable_gate_a : assert property ( // [RULE1]
    conv_enable_o |-> ena_r && !off_state_i)
    else $error("converter on without enable");

  sleep_follow_a : assert property ( // [RULE2]
    sleep_state_i && slp_r && !off_state_i |-> conv_enable_o == ena_r)
    else $error("sleep enable not followed");

  result_hold_a : assert property ( // [RULE12]
    !(state_r == ACS_WAIT && conv_done_i) |=> $stable(result_r))
    else $error("result changed without measurement");

endmodule // acs_sequencer
`default_nettype wire

// [bench/acs_conv_model.sv]
`timescale 1ns/1ps
`default_nettype none
module acs_conv_model
#(
  parameter int LAT = 3
)
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // converter side of the sequencer
  input  wire logic        start_i,
  input  wire logic [3:0]  source_i,
  output logic             done_o,
  output logic      [11:0] data_o
);
  logic [3:0]  cnt_r;
  logic [11:0] last_r;

  // data line shows the inverse of the last code outside the done cycle
  assign data_o = done_o ? last_r : ~last_r;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt_r  <= 4'h0;
      done_o <= 1'b0;
      last_r <= 12'h000;
    end
    else
    begin
      done_o <= 1'b0;
      if (start_i)
        cnt_r <= LAT[3:0];
      else if (cnt_r != 4'h0)
      begin
        cnt_r <= cnt_r - 4'h1;
        if (cnt_r == 4'h1)
        begin
          done_o <= 1'b1;
          last_r <= {source_i, 8'ha5};
        end
      end
    end
  end
endmodule // acs_conv_model
`default_nettype wire

// [bench/acs_sequencer_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer_tb;
  import acs_pkg::*;
  localparam int HZ = 4000;
  logic        clk_i;
  logic        rst_i;
  logic [15:0] avs_address_i;
  logic        avs_read_i;
  logic        avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        off_state_i;
  logic        sleep_state_i;
  logic        conv_enable_o;
  logic        conv_start_o;
  logic [3:0]  conv_source_o;
  logic        conv_done_i;
  logic [11:0] conv_data_i;
  logic        irq_o;
  int          err_total;
  int          tests_run;
  int          starts = 0;
  int          s0;

  acs_sequencer #(.CLK_HZ(HZ)) acs_sequencer_inst (.clk_i(clk_i), .rst_i(rst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'h3),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .off_state_i(off_state_i), .sleep_state_i(sleep_state_i),
    .conv_enable_o(conv_enable_o), .conv_start_o(conv_start_o),
    .conv_source_o(conv_source_o), .conv_done_i(conv_done_i),
    .conv_data_i(conv_data_i), .irq_o(irq_o));

  acs_conv_model acs_conv_model_inst (.clk_i(clk_i), .rst_i(rst_i),
    .start_i(conv_start_o), .source_i(conv_source_o), .done_o(conv_done_i),
    .data_o(conv_data_i));

  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // starts counted mid-cycle, clear of the launching edge
  always @(negedge clk_i)
    if (conv_start_o === 1'b1)
      starts <= starts + 1;

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // request held from a rising edge until the edge where waitrequest is low
  task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d,
                     output logic [15:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address_i   <= a;
    avs_writedata_i <= {16'h0000, d};
    avs_write_i     <= w;
    avs_read_i      <= ~w;
    @(posedge clk_i);
    while (avs_waitrequest_o !== 1'b0 && n < 50)
    begin
      n++;
      @(posedge clk_i);
    end
    if (n >= 50)
      chk("waitrequest", 32'h0, 32'h1);
    r = avs_readdata_o[15:0];
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
    @(negedge clk_i);
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    logic [15:0] dummy;
    acc(1'b1, a, d, dummy);
  endtask

  task automatic rd(input string what, input logic [15:0] a, input logic [15:0] exp);
    logic [15:0] r;
    acc(1'b0, a, 16'h0000, r);
    chk(what, {16'h0000, exp}, {16'h0000, r});
  endtask

  task automatic wait_irq();
    int n;
    n = 0;
    @(negedge clk_i);
    while (irq_o !== 1'b1 && n < 200)
    begin
      n++;
      @(negedge clk_i);
    end
    chk("irq raised", 32'h1, {31'h0, irq_o});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #500_000;
    err_total++;
    summarize();
  end

  initial
  begin : main
    logic [3:0]  tags [3];
    logic [5:0]  codes [3];
    int          wins [3];
    int          cnts [3];
    tags = '{4'h3, 4'h7, 4'h1};
    codes = '{6'h01, 6'h21, 6'h20};
    wins = '{4100, 1100, 1100};
    cnts = '{2, 4, 0};
    err_total = 0;
    tests_run = 0;
    rst_i = 1'b1;
    avs_address_i = 16'h0000;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0;
    off_state_i = 1'b0;
    sleep_state_i = 1'b0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd("control reset", ACS_IDX_CONTROL, 16'h0000);
    rd("source reset", ACS_IDX_SOURCE, 16'h0000);
    rd("result reset", ACS_IDX_RESULT, 16'h0000);
    rd("irq enable reset", ACS_IDX_IRQ_EN, 16'h0000);
    rd("unmapped", 16'h4100, 16'h0000);
    chk("enable off", 32'h0, {31'h0, conv_enable_o});
    wr(ACS_IDX_SOURCE, 16'h007f);
    rd("source bits", ACS_IDX_SOURCE, 16'h0057);
    wr(ACS_IDX_SOURCE, 16'h0045);
    // first conversion with the interrupt masked
    wr(ACS_IDX_CONTROL, 16'hc000);
    repeat (20) @(negedge clk_i);
    chk("irq masked", 32'h0, {31'h0, irq_o});
    wr(ACS_IDX_IRQ_EN, 16'h0001);
    @(negedge clk_i);
    chk("irq unmasked", 32'h1, {31'h0, irq_o});
    rd("status done", ACS_IDX_IRQ_STS, 16'h0001);
    @(negedge clk_i);
    chk("irq cleared", 32'h0, {31'h0, irq_o});
    rd("result first pin", ACS_IDX_RESULT, 16'h11a5);
    rd("control self clear", ACS_IDX_CONTROL, 16'h8000);
    for (int i = 0; i < 3; i++)
    begin
      wr(ACS_IDX_CONTROL, 16'hc000);
      wait_irq();
      rd("status done", ACS_IDX_IRQ_STS, 16'h0001);
      rd("result order", ACS_IDX_RESULT, {tags[i], tags[i], 8'ha5});
    end
    chk("one start per trigger", 32'd4, starts);
    // power states gate the converter
    chk("enable on", 32'h1, {31'h0, conv_enable_o});
    @(posedge clk_i);
    sleep_state_i <= 1'b1;
    @(negedge clk_i);
    chk("sleep off", 32'h0, {31'h0, conv_enable_o});
    wr(ACS_IDX_CONTROL, 16'h9000);
    @(negedge clk_i);
    chk("sleep follows", 32'h1, {31'h0, conv_enable_o});
    @(posedge clk_i);
    off_state_i <= 1'b1;
    @(negedge clk_i);
    chk("off gate", 32'h0, {31'h0, conv_enable_o});
    rd("off clears enable", ACS_IDX_CONTROL, 16'h1000);
    @(posedge clk_i);
    off_state_i   <= 1'b0;
    sleep_state_i <= 1'b0;
    // trigger with nothing selected
    wr(ACS_IDX_SOURCE, 16'h0000);
    s0 = starts;
    wr(ACS_IDX_CONTROL, 16'hc000);
    repeat (20) @(negedge clk_i);
    chk("no start", s0, starts);
    rd("bit cleared", ACS_IDX_CONTROL, 16'h8000);
    rd("result kept", ACS_IDX_RESULT, 16'h11a5);
    // automatic rates on the temperature source only
    wr(ACS_IDX_SOURCE, 16'h0010);
    for (int i = 0; i < 3; i++)
    begin
      wr(ACS_IDX_CONTROL, {10'h300, codes[i]});
      s0 = starts;
      repeat (wins[i]) @(negedge clk_i);
      chk("auto starts", cnts[i], starts - s0);
      rd("auto bit held", ACS_IDX_CONTROL, {10'h300, codes[i]});
      wr(ACS_IDX_CONTROL, 16'h8000);
      repeat (20) @(negedge clk_i);
      rd("auto status", ACS_IDX_IRQ_STS, (cnts[i] != 0) ? 16'h0001 : 16'h0000);
    end
    rd("result temp", ACS_IDX_RESULT, 16'h55a5);
    summarize();
  end
endmodule // acs_sequencer_tb
`default_nettype wire
